// >>> dv/tof_firstwave_fire_config_props.sv
`timescale 1ns/1ns
module tof_firstwave_fire_config_props (
   input wire logic                         CLK_IN,
   input wire logic                         SYS_RST_IN,
   input wire logic [7:0]                   S_AXI_AWADDR_IN,
   input wire logic                         S_AXI_AWVALID_IN,
   input wire logic                         S_AXI_AWREADY_OUT,
   input wire logic [31:0]                  S_AXI_WDATA_IN,
   input wire logic [3:0]                   S_AXI_WSTRB_IN,
   input wire logic                         S_AXI_WVALID_IN,
   input wire logic                         S_AXI_WREADY_OUT,
   input wire logic [1:0]                   S_AXI_BRESP_OUT,
   input wire logic                         S_AXI_BVALID_OUT,
   input wire logic                         S_AXI_BREADY_IN,
   input wire logic [7:0]                   S_AXI_ARADDR_IN,
   input wire logic                         S_AXI_ARVALID_IN,
   input wire logic                         S_AXI_ARREADY_OUT,
   input wire logic [31:0]                  S_AXI_RDATA_OUT,
   input wire logic [1:0]                   S_AXI_RRESP_OUT,
   input wire logic                         S_AXI_RVALID_OUT,
   input wire logic                         S_AXI_RREADY_IN,
   input wire tof_cfg_pkg::first_wave_cfg_s FIRST_WAVE_CFG_OUT,
   input wire tof_cfg_pkg::fire_cfg_s       FIRE_CFG_OUT
);
   import tof_cfg_pkg::*;
   logic aw_hs;
   logic ar_hs;
   assign aw_hs = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
   assign ar_hs = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (SYS_RST_IN);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   a_write_answer: assert property (aw_hs |-> ##1 !S_AXI_BVALID_OUT ##1 S_AXI_BVALID_OUT)
      else $error("write response not two cycles after handshake");
   a_read_answer: assert property (ar_hs |-> ##1 !S_AXI_RVALID_OUT ##1 S_AXI_RVALID_OUT)
      else $error("read data not two cycles after handshake");
   a_resp_stands: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
      S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)) else $error("write response dropped");
   a_data_stands: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
      S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("read data dropped");
   a_fire_both: assert property (FIRE_CFG_OUT.fire_down_invert |->
      FIRE_CFG_OUT.fire_up_enable && FIRE_CFG_OUT.fire_down_enable)
      else $error("both-output mode without both outputs");
   a_delay_masked: assert property (FIRST_WAVE_CFG_OUT.first_wave_mode |->
      FIRST_WAVE_CFG_OUT.hit3_stop_delay == '0) else $error("delay seen in first-wave mode");
   a_plain_layout: assert property (!FIRST_WAVE_CFG_OUT.first_wave_mode |->
      FIRST_WAVE_CFG_OUT.comparator_offset_mv == '0 && !FIRST_WAVE_CFG_OUT.pulse_width_enable
      && !FIRST_WAVE_CFG_OUT.first_wave_edge_select) else $error("first-wave fields leak");
   a_cfg_holds: assert property (!$stable({FIRST_WAVE_CFG_OUT, FIRE_CFG_OUT}) |->
      $past(S_AXI_BVALID_OUT) || $past(SYS_RST_IN) || $past(SYS_RST_IN, 2))
      else $error("config changed without write");
   c_write: cover property (aw_hs);
   c_read: cover property (ar_hs);
   c_refused: cover property (S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == RESP_SLVERR);
   c_first_wave: cover property (FIRST_WAVE_CFG_OUT.first_wave_mode);
endmodule : tof_firstwave_fire_config_props

bind tof_firstwave_fire_config tof_firstwave_fire_config_props u_props (.*);

// >>> dv/tof_firstwave_fire_config_test.sv
`timescale 1ns/1ns
module tof_firstwave_fire_config_test;
   import tof_cfg_pkg::*;
   logic            CLK_IN = 0, SYS_RST_IN = 1;
   logic [7:0]      S_AXI_AWADDR_IN = '0, S_AXI_ARADDR_IN = '0;
   logic [31:0]     S_AXI_WDATA_IN = '0, S_AXI_RDATA_OUT, rng = 32'hbaa7df6e, d;
   logic [3:0]      S_AXI_WSTRB_IN = '0, s;
   logic            S_AXI_AWVALID_IN = 0, S_AXI_WVALID_IN = 0, S_AXI_BREADY_IN = 0;
   logic            S_AXI_ARVALID_IN = 0, S_AXI_RREADY_IN = 0;
   logic            S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT;
   logic            S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT;
   logic [1:0]      S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
   first_wave_cfg_s FIRST_WAVE_CFG_OUT;
   fire_cfg_s       FIRE_CFG_OUT;
   int              errors = 0, n_compared = 0, fc = 0;
   logic [31:0]     mdl [3];
   logic [7:0]      adr [6] = '{8'h00, 8'h10, 8'h14, 8'h08, 8'h12, 8'h3c};
   logic [7:0]      a;

   tof_firstwave_fire_config u_tof_firstwave_fire_config (.*);

   always #50 CLK_IN = ~CLK_IN;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : rnd

   function automatic int slot(logic [7:0] x);
      case (x)
         8'h00: return 0;
         8'h10: return 1;
         8'h14: return 2;
         default: return -1;
      endcase
   endfunction : slot

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic chk_cfg();
      first_wave_cfg_s f;
      fire_cfg_s       p;
      int              o;
      o = int'(mdl[1][12:8]) - (mdl[1][12] ? 32 : 0);
      o = o + (mdl[1][14] ? 20 : 0) - (mdl[1][13] ? 20 : 0);
      f.first_wave_mode = mdl[0][0];
      f.stop_analog_sel = mdl[0][1];
      f.hit3_stop_delay = mdl[0][0] ? 19'h0 : mdl[1][26:8];
      f.pulse_width_enable = mdl[0][0] & ~mdl[1][16];
      f.first_wave_edge_select = mdl[0][0] & mdl[1][15];
      f.comparator_offset_mv = mdl[0][0] ? 7'(o) : 7'h0;
      f.user_tag_reg4 = mdl[1][7:0];
      p.fire_up_enable = mdl[2][30] | mdl[2][31];
      p.fire_down_enable = mdl[2][29] | mdl[2][31];
      p.fire_down_invert = mdl[2][31];
      p.start_noise_enable = mdl[2][28];
      p.phase_noise_enable = ~mdl[2][27];
      p.fire_repeat = mdl[2][26:24];
      p.per_pulse_phase_reverse = mdl[2][22:8];
      p.user_tag_reg5 = mdl[2][7:0];
      chk("first_wave_cfg", 64'(f), 64'(FIRST_WAVE_CFG_OUT));
      chk("fire_cfg", 64'(p), 64'(FIRE_CFG_OUT));
   endtask : chk_cfg
   // ---------------------------------------------------------------
   // bus master
   // ---------------------------------------------------------------
   task automatic axi_wr(logic [7:0] x, logic [31:0] v, logic [3:0] m);
      int k;
      k = slot(x);
      S_AXI_AWADDR_IN <= x;
      S_AXI_WDATA_IN <= v;
      S_AXI_WSTRB_IN <= m;
      S_AXI_AWVALID_IN <= 1;
      S_AXI_WVALID_IN <= 1;
      repeat (60) begin
         @(posedge CLK_IN);
         if (S_AXI_AWREADY_OUT) S_AXI_AWVALID_IN <= 0;
         if (S_AXI_WREADY_OUT) S_AXI_WVALID_IN <= 0;
         if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
            chk("bresp", (k < 0) ? 64'(RESP_SLVERR) : 64'(RESP_OKAY), 64'(S_AXI_BRESP_OUT));
            S_AXI_BREADY_IN <= 0;
            for (int b = 0; b < 4; b++) if (k >= 0 && m[b]) mdl[k][b*8 +: 8] = v[b*8 +: 8];
            return;
         end
         if (rnd() > 32'h80000000) S_AXI_BREADY_IN <= 1;
      end
      errors++;
      conclude();
   endtask : axi_wr

   task automatic axi_rd(logic [7:0] x);
      int k;
      k = slot(x);
      S_AXI_ARADDR_IN <= x;
      S_AXI_ARVALID_IN <= 1;
      repeat (60) begin
         @(posedge CLK_IN);
         if (S_AXI_ARREADY_OUT) S_AXI_ARVALID_IN <= 0;
         if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
            chk("rresp", (k < 0) ? 64'(RESP_SLVERR) : 64'(RESP_OKAY), 64'(S_AXI_RRESP_OUT));
            chk("rdata", (k < 0) ? 64'h0 : 64'(mdl[k]), 64'(S_AXI_RDATA_OUT));
            S_AXI_RREADY_IN <= 0;
            return;
         end
         if (rnd() > 32'h80000000) S_AXI_RREADY_IN <= 1;
      end
      errors++;
      conclude();
   endtask : axi_rd
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      mdl[0] = CTRL_RST;
      mdl[1] = REG4_RST;
      mdl[2] = REG5_RST;
      repeat (2) @(posedge CLK_IN);
      SYS_RST_IN <= 0;
      repeat (2) @(posedge CLK_IN);
      chk_cfg();
      for (int i = 0; i < 6; i++) axi_rd(adr[i]);
      for (int i = 0; i < 90; i++) begin
         a = adr[rnd() % 6];
         d = rnd();
         s = (i % 3 == 0) ? 4'(rnd()) : 4'hf;
         if (a == 8'h00 && mdl[1][26:8] != 19'h0) d[1] = 1'b1;
         if (a == 8'h10) d[31:27] = 5'b00100;
         if (a == 8'h10 && mdl[0][1:0] == 2'b00) d[26:8] = 19'h0;
         if (a == 8'h14) begin
            fc = (fc % 8 == 2) ? fc + 2 : fc + 1;
            d[31:29] = 3'(fc);
            d[23] = 1'b0;
         end
         axi_wr(a, d, s);
         @(posedge CLK_IN);
         chk_cfg();
         if (i % 4 == 0) axi_rd(a);
      end
      // mid-run reset restores the default words
      SYS_RST_IN <= 1;
      repeat (2) @(posedge CLK_IN);
      SYS_RST_IN <= 0;
      mdl[0] = CTRL_RST;
      mdl[1] = REG4_RST;
      mdl[2] = REG5_RST;
      repeat (2) @(posedge CLK_IN);
      chk_cfg();
      for (int i = 0; i < 3; i++) axi_rd(adr[i]);
      conclude();
   end
endmodule : tof_firstwave_fire_config_test

// >>> pkg/tof_cfg_pkg.sv
package tof_cfg_pkg;

   // ---------------------------------------------------------------
   // bus geometry
   // ---------------------------------------------------------------
   localparam int          DATA_W      = 32;
   localparam int          ADDR_W      = 8;
   localparam int          IDX_W       = ADDR_W - 2;
   localparam int          SLOTS       = 3;
   localparam int          SLOT_W      = 2;

   // register indices, byte address is four times the index
   localparam logic [5:0]  IDX_CTRL    = 6'h00;
   localparam logic [5:0]  IDX_REG4    = 6'h04;
   localparam logic [5:0]  IDX_REG5    = 6'h05;

   localparam logic [1:0]  SLOT_CTRL   = 2'h0;
   localparam logic [1:0]  SLOT_REG4   = 2'h1;
   localparam logic [1:0]  SLOT_REG5   = 2'h2;

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [31:0] REG4_RST    = 32'h2000_0000;
   localparam logic [31:0] REG5_RST    = 32'h0000_0000;

   // ---------------------------------------------------------------
   // field layout
   // ---------------------------------------------------------------
   localparam int          CTRL_FW_BIT     = 0;
   localparam int          CTRL_ANALOG_BIT = 1;

   localparam int          TAG_LSB     = 0;
   localparam int          TAG_MSB     = 7;
   localparam int          HIT3_LSB    = 8;
   localparam int          HIT3_MSB    = 26;
   localparam int          PULSE_WIDTH_DISABLE_BIT  = 16;
   localparam int          EDGE_BIT    = 15;
   localparam int          PLUS_BIT    = 14;
   localparam int          MINUS_BIT   = 13;
   localparam int          COMPARATOR_OFFSET_TRIM_LSB    = 8;
   localparam int          COMPARATOR_OFFSET_TRIM_MSB    = 12;

   localparam int          BOTH_BIT    = 31;
   localparam int          UP_BIT      = 30;
   localparam int          DOWN_BIT    = 29;
   localparam int          NOISE_BIT   = 28;
   localparam int          PHN_DIS_BIT = 27;
   localparam int          REP_LSB     = 24;
   localparam int          REP_MSB     = 26;
   localparam int          PHREV_LSB   = 8;
   localparam int          PHREV_MSB   = 22;

   // extra comparator shift in mV, offset result width
   localparam int          COMPARATOR_OFFSET_TRIM_MV_W   = 7;
   localparam logic [6:0]  RANGE_SHIFT = 7'h14;

   // ---------------------------------------------------------------
   // carriers and states
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        first_wave_mode;
      logic        stop_analog_sel;
      logic [18:0] hit3_stop_delay;
      logic        pulse_width_enable;
      logic        first_wave_edge_select;
      logic [6:0]  comparator_offset_mv;
      logic [7:0]  user_tag_reg4;
   } first_wave_cfg_s;

   typedef struct packed {
      logic        fire_up_enable;
      logic        fire_down_enable;
      logic        fire_down_invert;
      logic        start_noise_enable;
      logic        phase_noise_enable;
      logic [2:0]  fire_repeat;
      logic [14:0] per_pulse_phase_reverse;
      logic [7:0]  user_tag_reg5;
   } fire_cfg_s;

   typedef enum logic [0:0] {WR_IDLE, WR_RESP} wr_state_e;
   typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} rd_state_e;

endpackage : tof_cfg_pkg

// >>> rtl/cfg_word_store.sv
`timescale 1ns/1ns
module cfg_word_store #(
   parameter int                      WORDS = 3,
   parameter int                      W     = 32,
   parameter logic [WORDS*W-1:0]      RST   = '0
) (
   input  wire logic                  CLK_IN,
   input  wire logic                  SYS_RST_IN,
   input  wire logic                  WR_EN_IN,
   input  wire logic [1:0]            WR_IDX_IN,
   input  wire logic [W-1:0]          WR_DATA_IN,
   input  wire logic [W/8-1:0]        WR_STRB_IN,
   input  wire logic                  RD_EN_IN,
   input  wire logic [1:0]            RD_IDX_IN,
   output logic      [W-1:0]          RD_DATA_OUT,
   output logic      [WORDS*W-1:0]    WORDS_OUT
);
   typedef struct packed {
      logic [WORDS*W-1:0] mem;
      logic [W-1:0]       rd;
   } store_s;

   store_s s_q;
   store_s s_d;

   // ---------------------------------------------------------------
   // byte-lane write, registered read
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      for (int i = 0; i < W/8; i++) begin
         if (WR_EN_IN && WR_STRB_IN[i]) begin
            s_d.mem[WR_IDX_IN*W + i*8 +: 8] = WR_DATA_IN[i*8 +: 8];
         end
      end
      if (RD_EN_IN) begin
         s_d.rd = s_q.mem[RD_IDX_IN*W +: W];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         s_q <= '{mem: RST, rd: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign RD_DATA_OUT = s_q.rd;
   assign WORDS_OUT   = s_q.mem;

endmodule : cfg_word_store

// >>> rtl/tof_firstwave_fire_config.sv
`timescale 1ns/1ns
module tof_firstwave_fire_config (
   input  wire logic                                CLK_IN,
   input  wire logic                                SYS_RST_IN,
   input  wire logic [tof_cfg_pkg::ADDR_W-1:0]      S_AXI_AWADDR_IN,
   input  wire logic                                S_AXI_AWVALID_IN,
   output logic                                     S_AXI_AWREADY_OUT,
   input  wire logic [tof_cfg_pkg::DATA_W-1:0]      S_AXI_WDATA_IN,
   input  wire logic [tof_cfg_pkg::DATA_W/8-1:0]    S_AXI_WSTRB_IN,
   input  wire logic                                S_AXI_WVALID_IN,
   output logic                                     S_AXI_WREADY_OUT,
   output logic [1:0]                               S_AXI_BRESP_OUT,
   output logic                                     S_AXI_BVALID_OUT,
   input  wire logic                                S_AXI_BREADY_IN,
   input  wire logic [tof_cfg_pkg::ADDR_W-1:0]      S_AXI_ARADDR_IN,
   input  wire logic                                S_AXI_ARVALID_IN,
   output logic                                     S_AXI_ARREADY_OUT,
   output logic [tof_cfg_pkg::DATA_W-1:0]           S_AXI_RDATA_OUT,
   output logic [1:0]                               S_AXI_RRESP_OUT,
   output logic                                     S_AXI_RVALID_OUT,
   input  wire logic                                S_AXI_RREADY_IN,
   output tof_cfg_pkg::first_wave_cfg_s             FIRST_WAVE_CFG_OUT,
   output tof_cfg_pkg::fire_cfg_s                   FIRE_CFG_OUT
);
   import tof_cfg_pkg::*;

   typedef struct packed {
      wr_state_e          wr_state;
      logic               awready;
      logic               wready;
      logic               aw_have;
      logic               w_have;
      logic               w_ok;
      logic [SLOT_W-1:0]  w_slot;
      logic [DATA_W-1:0]  wdata;
      logic [DATA_W/8-1:0] wstrb;
      logic               bvalid;
      logic [1:0]         bresp;
      rd_state_e          rd_state;
      logic               arready;
      logic               r_ok;
      logic               rvalid;
      logic [1:0]         rresp;
      logic [DATA_W-1:0]  rdata;
      first_wave_cfg_s    fw;
      fire_cfg_s          fire;
   } state_s;

   localparam state_s ST_RST = '{
      wr_state: WR_IDLE,
      awready:  1'b1,
      wready:   1'b1,
      aw_have:  1'b0,
      w_have:   1'b0,
      w_ok:     1'b0,
      w_slot:   SLOT_CTRL,
      wdata:    '0,
      wstrb:    '0,
      bvalid:   1'b0,
      bresp:    RESP_OKAY,
      rd_state: RD_IDLE,
      arready:  1'b1,
      r_ok:     1'b0,
      rvalid:   1'b0,
      rresp:    RESP_OKAY,
      rdata:    '0,
      fw:       '0,
      fire:     '0
   };

   state_s                   s_q;
   state_s                   s_d;
   logic                     st_wr_en;
   logic [SLOT_W-1:0]        st_wr_idx;
   logic                     st_rd_en;
   logic [SLOT_W-1:0]        st_rd_idx;
   logic [DATA_W-1:0]        st_rd_data;
   logic [SLOTS*DATA_W-1:0]  st_words;
   logic [DATA_W-1:0]        word_w [SLOTS];
   logic [DATA_W-1:0]        ctrl_w;
   logic [DATA_W-1:0]        reg4_w;
   logic [DATA_W-1:0]        reg5_w;

   // ---------------------------------------------------------------
   // address decode: {hit, slot}
   // ---------------------------------------------------------------
   function automatic logic [SLOT_W:0] slot_of(input logic [ADDR_W-1:0] a);
      logic [IDX_W-1:0] idx;
      logic             al;
      idx = a[ADDR_W-1:2];
      al  = (a[1:0] == 2'h0);
      if (al && idx == IDX_CTRL) begin
         return {1'b1, SLOT_CTRL};
      end else if (al && idx == IDX_REG4) begin
         return {1'b1, SLOT_REG4};
      end else if (al && idx == IDX_REG5) begin
         return {1'b1, SLOT_REG5};
      end
      return {1'b0, SLOT_CTRL};
   endfunction : slot_of

   // ---------------------------------------------------------------
   // register words
   // ---------------------------------------------------------------
   cfg_word_store #(
      .WORDS (SLOTS),
      .W     (DATA_W),
      .RST   ({REG5_RST, REG4_RST, CTRL_RST})
   ) u_store (
      .CLK_IN      (CLK_IN),
      .SYS_RST_IN  (SYS_RST_IN),
      .WR_EN_IN    (st_wr_en),
      .WR_IDX_IN   (st_wr_idx),
      .WR_DATA_IN  (s_q.wdata),
      .WR_STRB_IN  (s_q.wstrb),
      .RD_EN_IN    (st_rd_en),
      .RD_IDX_IN   (st_rd_idx),
      .RD_DATA_OUT (st_rd_data),
      .WORDS_OUT   (st_words)
   );

   // ---------------------------------------------------------------
   // per-slot word views
   // ---------------------------------------------------------------
   for (genvar g = 0; g < SLOTS; g++) begin : g_word
      assign word_w[g] = st_words[g*DATA_W +: DATA_W];
   end

   assign ctrl_w = word_w[SLOT_CTRL];
   assign reg4_w = word_w[SLOT_REG4];
   assign reg5_w = word_w[SLOT_REG5];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [SLOT_W:0]     hit;
      logic                fw_on;
      logic [COMPARATOR_OFFSET_TRIM_MV_W-1:0] off;
      hit       = '0;
      fw_on     = 1'b0;
      off       = '0;
      s_d       = s_q;
      st_wr_en  = 1'b0;
      st_wr_idx = s_q.w_slot;
      st_rd_en  = 1'b0;
      st_rd_idx = SLOT_CTRL;

      // ------------------------------------------------------------
      // write channel, address and data in either order
      // ------------------------------------------------------------
      unique case (s_q.wr_state)
         WR_IDLE: begin
            if (S_AXI_AWVALID_IN && s_q.awready) begin
               hit         = slot_of(S_AXI_AWADDR_IN);
               s_d.aw_have = 1'b1;
               s_d.awready = 1'b0;
               s_d.w_ok    = hit[SLOT_W];
               s_d.w_slot  = hit[SLOT_W-1:0];
            end
            if (S_AXI_WVALID_IN && s_q.wready) begin
               s_d.w_have = 1'b1;
               s_d.wready = 1'b0;
               s_d.wdata  = S_AXI_WDATA_IN;
               s_d.wstrb  = S_AXI_WSTRB_IN;
            end
            if (s_q.aw_have && s_q.w_have) begin
               st_wr_en     = s_q.w_ok;
               s_d.aw_have  = 1'b0;
               s_d.w_have   = 1'b0;
               s_d.bvalid   = 1'b1;
               s_d.bresp    = s_q.w_ok ? RESP_OKAY : RESP_SLVERR;
               s_d.wr_state = WR_RESP;
            end
         end
         WR_RESP: begin
            if (S_AXI_BREADY_IN) begin
               s_d.bvalid   = 1'b0;
               s_d.awready  = 1'b1;
               s_d.wready   = 1'b1;
               s_d.wr_state = WR_IDLE;
            end
         end
      endcase

      // ------------------------------------------------------------
      // read channel
      // ------------------------------------------------------------
      unique case (s_q.rd_state)
         RD_IDLE: begin
            if (S_AXI_ARVALID_IN) begin
               hit          = slot_of(S_AXI_ARADDR_IN);
               st_rd_en     = hit[SLOT_W];
               st_rd_idx    = hit[SLOT_W-1:0];
               s_d.r_ok     = hit[SLOT_W];
               s_d.arready  = 1'b0;
               s_d.rd_state = RD_FETCH;
            end
         end
         RD_FETCH: begin
            s_d.rdata    = s_q.r_ok ? st_rd_data : '0;
            s_d.rresp    = s_q.r_ok ? RESP_OKAY : RESP_SLVERR;
            s_d.rvalid   = 1'b1;
            s_d.rd_state = RD_RESP;
         end
         RD_RESP: begin
            if (S_AXI_RREADY_IN) begin
               s_d.rvalid   = 1'b0;
               s_d.arready  = 1'b1;
               s_d.rd_state = RD_IDLE;
            end
         end
         default: begin
            s_d.rd_state = RD_IDLE;
            s_d.arready  = 1'b1;
            s_d.rvalid   = 1'b0;
         end
      endcase

      // ------------------------------------------------------------
      // first-wave / hit-3 decode
      // ------------------------------------------------------------
      fw_on = ctrl_w[CTRL_FW_BIT];
      s_d.fw.first_wave_mode = fw_on;
      s_d.fw.stop_analog_sel = ctrl_w[CTRL_ANALOG_BIT];
      s_d.fw.hit3_stop_delay = fw_on ? '0 : reg4_w[HIT3_MSB:HIT3_LSB];
      s_d.fw.pulse_width_enable = fw_on & ~reg4_w[PULSE_WIDTH_DISABLE_BIT];
      s_d.fw.first_wave_edge_select = fw_on & reg4_w[EDGE_BIT];
      off = {{(COMPARATOR_OFFSET_TRIM_MV_W-(COMPARATOR_OFFSET_TRIM_MSB-COMPARATOR_OFFSET_TRIM_LSB+1)){reg4_w[COMPARATOR_OFFSET_TRIM_MSB]}},
             reg4_w[COMPARATOR_OFFSET_TRIM_MSB:COMPARATOR_OFFSET_TRIM_LSB]};
      if (reg4_w[PLUS_BIT]) begin
         off = off + RANGE_SHIFT;
      end
      if (reg4_w[MINUS_BIT]) begin
         off = off - RANGE_SHIFT;
      end
      s_d.fw.comparator_offset_mv = fw_on ? off : '0;
      s_d.fw.user_tag_reg4 = reg4_w[TAG_MSB:TAG_LSB];

      // ------------------------------------------------------------
      // fire pulse generator decode
      // ------------------------------------------------------------
      s_d.fire.fire_up_enable   = reg5_w[UP_BIT] | reg5_w[BOTH_BIT];
      s_d.fire.fire_down_enable = reg5_w[DOWN_BIT] | reg5_w[BOTH_BIT];
      s_d.fire.fire_down_invert = reg5_w[BOTH_BIT];
      s_d.fire.start_noise_enable = reg5_w[NOISE_BIT];
      s_d.fire.phase_noise_enable = ~reg5_w[PHN_DIS_BIT];
      s_d.fire.fire_repeat = reg5_w[REP_MSB:REP_LSB];
      s_d.fire.per_pulse_phase_reverse = reg5_w[PHREV_MSB:PHREV_LSB];
      s_d.fire.user_tag_reg5 = reg5_w[TAG_MSB:TAG_LSB];
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // bus outputs
   // ---------------------------------------------------------------
   assign S_AXI_AWREADY_OUT  = s_q.awready;
   assign S_AXI_WREADY_OUT   = s_q.wready;
   assign S_AXI_BVALID_OUT   = s_q.bvalid;
   assign S_AXI_BRESP_OUT    = s_q.bresp;
   assign S_AXI_ARREADY_OUT  = s_q.arready;
   assign S_AXI_RVALID_OUT   = s_q.rvalid;
   assign S_AXI_RRESP_OUT    = s_q.rresp;
   assign S_AXI_RDATA_OUT    = s_q.rdata;

   // ---------------------------------------------------------------
   // configuration outputs
   // ---------------------------------------------------------------
   assign FIRST_WAVE_CFG_OUT = s_q.fw;
   assign FIRE_CFG_OUT       = s_q.fire;

endmodule : tof_firstwave_fire_config
